// ---- rtl/fer_pkg.sv ----
package fer_pkg;

    // ==========================================
    // register numbers
    localparam logic [3:0] REG_DIR_CUR   = 4'h1;
    localparam logic [3:0] REG_RES_VOLT  = 4'h2;
    localparam logic [3:0] REG_RES_CNT   = 4'h3;
    localparam logic [3:0] REG_LOW_CNT   = 4'h4;
    localparam logic [3:0] REG_HIGH_CNT  = 4'h5;
    localparam logic [3:0] REG_LOW_DUR   = 4'h6;
    localparam logic [3:0] REG_HIGH_DUR  = 4'h7;
    localparam logic [3:0] REG_NEUT_CUR  = 4'h8;
    localparam logic [3:0] DISP_BLANK    = 4'h0;

    // ==========================================
    // values and limits
    localparam logic [7:0]  REC_RESET    = 8'h00;
    localparam logic [7:0]  OVF_CODE     = 8'hff;
    localparam logic [7:0]  COUNT_MAX    = 8'hff;
    localparam logic [7:0]  DUR_FULL_PCT = 8'h64;
    localparam logic [7:0]  DUR_LAST_PCT = 8'h63;
    localparam logic [10:0] DIR_LIMIT    = 11'h064;
    localparam logic [10:0] VOLT_LIMIT   = 11'h019;
    localparam logic [10:0] NEUT_LIMIT   = 11'h064;
    localparam logic [16:0] DUR_STEP     = 17'h00064;

    // ==========================================
    // quantity and counter slots
    localparam int Q_DIR  = 0;
    localparam int Q_VOLT = 1;
    localparam int Q_NEUT = 2;
    localparam int C_RES  = 0;
    localparam int C_LOW  = 1;
    localparam int C_HIGH = 2;

    // ==========================================
    // timing: one millisecond tick
    localparam int CLK_PERIOD_NS  = 100;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int TICK_W         = 14;

endpackage

// ---- rtl/fer_duration.sv ----
`timescale 1ns/10ps
module fer_duration (
    input  wire logic        ref_clk_i,
    input  wire logic        srst_i,
    input  wire logic        tick_i,
    input  wire logic        clear_i,
    input  wire logic        start_i,
    input  wire logic        operate_i,
    input  wire logic [15:0] op_time_ms_i,
    output logic      [7:0]  pct_o
);

    typedef struct packed {
        logic [16:0] acc;
        logic [7:0]  pct;
        logic        prev_start;
        logic        prev_op;
    } fer_dur_state_type;

    fer_dur_state_type q;
    fer_dur_state_type next_q;
    logic              start_rise;
    logic              op_rise;

    assign start_rise = start_i & ~q.prev_start;
    assign op_rise    = operate_i & ~q.prev_op;

    // ==========================================
    // percent-of-operate-time counter
    always_comb begin
        next_q            = q;
        next_q.prev_start = start_i;
        next_q.prev_op    = operate_i;
        if (clear_i) begin
            next_q.acc = '0;
            next_q.pct = fer_pkg::REC_RESET;
        end
        if (op_rise) begin
            next_q.pct = fer_pkg::DUR_FULL_PCT;
        end else if (start_rise) begin
            next_q.acc = '0;
            next_q.pct = fer_pkg::REC_RESET;
        end else if (start_i && !operate_i && q.pct < fer_pkg::DUR_LAST_PCT) begin
            // percent-milliseconds: +100 per ms, -op_time per percent
            if (tick_i) begin
                next_q.acc = q.acc + fer_pkg::DUR_STEP;
            end else if (q.acc >= {1'b0, op_time_ms_i}) begin
                next_q.acc = q.acc - {1'b0, op_time_ms_i};
                next_q.pct = q.pct + 8'h01;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign pct_o = q.pct;

    // ==========================================
    // checks
    sequence s_op_rise;
        operate_i && !q.prev_op;
    endsequence

    sequence s_fresh_start;
        start_i && !q.prev_start && !(operate_i && !q.prev_op);
    endsequence

    a_dur_full: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        s_op_rise |=> pct_o == fer_pkg::DUR_FULL_PCT)
        else $error("duration not 100 after operate");

    a_dur_restart: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        s_fresh_start |=> pct_o == fer_pkg::REC_RESET ##1 pct_o <= 8'h01)
        else $error("duration not restarted from zero");

endmodule // fer_duration

// ---- rtl/fer_recorder.sv ----
// Operation
// - display shows register number, then value
// - register 1: directional current, sign flagged
// - register 1 overflow code above 100 percent
// - records update only on start or operate
// - track maximum while started, not operated
// - new start discards record, restarts tracking
// - operate captures value at operate instant
// - register 2: residual voltage, overflow above 25
// - register 3 counts residual voltage starts
// - register 4 counts low-set stage starts
// - register 5 counts high-set stage starts
// - register 6: low-set start duration percent
// - register 7: high-set start duration percent
// - new start clears duration, counts up
// - operate sets duration register to 100
// - register 8: neutral current, overflow above 100
// - clear by both keys or clear command
// - clear records on auxiliary supply loss
`timescale 1ns/10ps
module fer_recorder #(
    parameter int TICK_CYCLES = fer_pkg::TICK_CYCLES
) (
    input  wire logic        ref_clk_i,
    input  wire logic        srst_i,
    input  wire logic        low_start_i,
    input  wire logic        low_operate_i,
    input  wire logic        high_start_i,
    input  wire logic        high_operate_i,
    input  wire logic        residual_start_i,
    input  wire logic [10:0] directional_current_i,
    input  wire logic [9:0]  residual_voltage_i,
    input  wire logic [9:0]  neutral_current_i,
    input  wire logic [15:0] low_operate_time_i,
    input  wire logic [15:0] high_operate_time_i,
    input  wire logic        step_key_i,
    input  wire logic        reset_key_i,
    input  wire logic        clear_records_command_i,
    input  wire logic        supply_lost_i,
    input  wire logic [3:0]  disp_sel_i,
    input  wire logic [3:0]  rd_addr_i,
    output logic      [3:0]  disp_addr_o,
    output logic             disp_minus_o,
    output logic      [7:0]  disp_value_o,
    output logic      [7:0]  rd_data_o,
    output logic             rd_minus_o
);

    typedef struct packed {
        logic [2:0][7:0]             rec;
        logic                        dir_neg;
        logic [2:0][7:0]             cnt;
        logic [2:0]                  prev_st;
        logic [1:0]                  prev_op;
        logic [fer_pkg::TICK_W-1:0]  tick_cnt;
        logic                        tick;
        logic [3:0]                  disp_addr;
        logic                        disp_minus;
        logic [7:0]                  disp_value;
        logic [7:0]                  rd_data;
        logic                        rd_minus;
    } fer_state_type;

    fer_state_type   q;
    fer_state_type   next_q;
    logic            clr;
    logic [2:0][7:0] enc;
    logic [10:0]     dir_mag;
    logic [2:0]      st_now;
    logic [2:0]      st_rise;
    logic [1:0]      op_now;
    logic            new_start;
    logic            new_op;
    logic            start_any;
    logic            op_any;
    logic [1:0][7:0] dur;
    logic [1:0][15:0] op_time;

    // ==========================================
    // helpers
    function automatic logic [7:0] sat_pct(input logic [10:0] v,
                                          input logic [10:0] lim);
        return (v > lim) ? fer_pkg::OVF_CODE : v[7:0];
    endfunction

    function automatic logic [7:0] reg_read(input logic [3:0]      a,
                                           input fer_state_type   s,
                                           input logic [1:0][7:0] d);
        logic [7:0] r;
        r = 8'h00;
        case (a)
            fer_pkg::REG_DIR_CUR:  r = s.rec[fer_pkg::Q_DIR];
            fer_pkg::REG_RES_VOLT: r = s.rec[fer_pkg::Q_VOLT];
            fer_pkg::REG_RES_CNT:  r = s.cnt[fer_pkg::C_RES];
            fer_pkg::REG_LOW_CNT:  r = s.cnt[fer_pkg::C_LOW];
            fer_pkg::REG_HIGH_CNT: r = s.cnt[fer_pkg::C_HIGH];
            fer_pkg::REG_LOW_DUR:  r = d[0];
            fer_pkg::REG_HIGH_DUR: r = d[1];
            fer_pkg::REG_NEUT_CUR: r = s.rec[fer_pkg::Q_NEUT];
            default:               r = 8'h00;
        endcase
        return r;
    endfunction

    function automatic logic is_mapped(input logic [3:0] a);
        return (a >= fer_pkg::REG_DIR_CUR) && (a <= fer_pkg::REG_NEUT_CUR);
    endfunction

    // ==========================================
    // event decode
    assign clr = (step_key_i & reset_key_i) | clear_records_command_i
               | supply_lost_i;
    assign st_now    = {high_start_i, low_start_i, residual_start_i};
    assign st_rise   = st_now & ~q.prev_st;
    assign op_now    = {high_operate_i, low_operate_i};
    assign new_start = st_rise[fer_pkg::C_LOW] | st_rise[fer_pkg::C_HIGH];
    assign new_op    = |(op_now & ~q.prev_op);
    assign start_any = low_start_i | high_start_i;
    assign op_any    = low_operate_i | high_operate_i;

    // ==========================================
    // scaled quantities, overflow coded
    assign dir_mag = directional_current_i[10] ? (11'h000 - directional_current_i)
                                               : directional_current_i;
    assign enc[fer_pkg::Q_DIR]  = sat_pct(dir_mag, fer_pkg::DIR_LIMIT);
    assign enc[fer_pkg::Q_VOLT] = sat_pct({1'b0, residual_voltage_i},
                                          fer_pkg::VOLT_LIMIT);
    assign enc[fer_pkg::Q_NEUT] = sat_pct({1'b0, neutral_current_i},
                                          fer_pkg::NEUT_LIMIT);

    // ==========================================
    // start duration trackers
    assign op_time[0] = low_operate_time_i;
    assign op_time[1] = high_operate_time_i;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_dur
            fer_duration u_dur (
                .ref_clk_i    (ref_clk_i),
                .srst_i       (srst_i),
                .tick_i       (q.tick),
                .clear_i      (clr),
                .start_i      (st_now[g + 1]),
                .operate_i    (op_now[g]),
                .op_time_ms_i (op_time[g]),
                .pct_o        (dur[g])
            );
        end
    endgenerate

    // ==========================================
    // next state
    always_comb begin
        next_q         = q;
        next_q.prev_st = st_now;
        next_q.prev_op = op_now;

        // millisecond tick divider
        next_q.tick = 1'b0;
        if (q.tick_cnt == fer_pkg::TICK_W'(TICK_CYCLES - 1)) begin
            next_q.tick_cnt = '0;
            next_q.tick     = 1'b1;
        end else begin
            next_q.tick_cnt = q.tick_cnt + 1'b1;
        end

        // clear first, so a same-cycle event still lands
        if (clr) begin
            next_q.rec     = '0;
            next_q.cnt     = '0;
            next_q.dir_neg = 1'b0;
        end

        for (int i = 0; i < 3; i++) begin
            if (st_rise[i] && next_q.cnt[i] != fer_pkg::COUNT_MAX) begin
                next_q.cnt[i] = next_q.cnt[i] + 8'h01;
            end
        end

        // sign decided against the record before it moves
        if (new_op || new_start ||
            (start_any && !op_any &&
             enc[fer_pkg::Q_DIR] > next_q.rec[fer_pkg::Q_DIR])) begin
            next_q.dir_neg = directional_current_i[10];
        end
        for (int i = 0; i < 3; i++) begin
            if (new_op) begin
                next_q.rec[i] = enc[i];
            end else if (new_start) begin
                next_q.rec[i] = enc[i];
            end else if (start_any && !op_any && enc[i] > next_q.rec[i]) begin
                next_q.rec[i] = enc[i];
            end
        end

        // display and serial readout
        next_q.disp_addr  = is_mapped(disp_sel_i) ? disp_sel_i : fer_pkg::DISP_BLANK;
        next_q.disp_value = reg_read(disp_sel_i, q, dur);
        next_q.disp_minus = (disp_sel_i == fer_pkg::REG_DIR_CUR) & q.dir_neg;
        next_q.rd_data    = reg_read(rd_addr_i, q, dur);
        next_q.rd_minus   = (rd_addr_i == fer_pkg::REG_DIR_CUR) & q.dir_neg;
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign disp_addr_o  = q.disp_addr;
    assign disp_minus_o = q.disp_minus;
    assign disp_value_o = q.disp_value;
    assign rd_data_o    = q.rd_data;
    assign rd_minus_o   = q.rd_minus;

    // ==========================================
    // checks
    sequence s_low_rise;
        low_start_i && !q.prev_st[fer_pkg::C_LOW] && !clr;
    endsequence

    sequence s_quiet;
        !start_any && !op_any && !clr;
    endsequence

    sequence s_op_capture;
        new_op && !clr;
    endsequence

    sequence s_high_rise;
        high_start_i && !q.prev_st[fer_pkg::C_HIGH] && !clr;
    endsequence

    sequence s_res_rise;
        residual_start_i && !q.prev_st[fer_pkg::C_RES] && !clr;
    endsequence

    sequence s_fresh;
        new_start && !new_op && !clr;
    endsequence

    sequence s_track;
        start_any && !op_any && !new_start && !new_op && !clr;
    endsequence

    sequence s_unmapped;
        !is_mapped(rd_addr_i);
    endsequence

    sequence s_dir_sel;
        rd_addr_i == fer_pkg::REG_DIR_CUR;
    endsequence

    a_count_step: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        s_low_rise ##0 (q.cnt[fer_pkg::C_LOW] != fer_pkg::COUNT_MAX)
        |=> q.cnt[fer_pkg::C_LOW] == $past(q.cnt[fer_pkg::C_LOW]) + 8'h01)
        else $error("low start count did not step");

    a_count_level: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (high_start_i && q.prev_st[fer_pkg::C_HIGH] && !clr)
        |=> $stable(q.cnt[fer_pkg::C_HIGH]))
        else $error("count moved while start held");

    a_count_sat: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (q.cnt[fer_pkg::C_LOW] == fer_pkg::COUNT_MAX && !clr)
        |=> q.cnt[fer_pkg::C_LOW] == fer_pkg::COUNT_MAX)
        else $error("start count wrapped");

    a_clear_all: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (clr && st_rise == 3'b000 && !new_op && !new_start && !start_any)
        |=> q.cnt == '0 && q.rec == '0)
        else $error("records not cleared");

    a_record_hold: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        s_quiet |=> $stable(q.rec))
        else $error("record changed without start");

    a_peak_track: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (start_any && !op_any && !new_start && !new_op && !clr)
        |=> q.rec[fer_pkg::Q_VOLT] >= $past(q.rec[fer_pkg::Q_VOLT]))
        else $error("peak record dropped");

    a_op_capture: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        s_op_capture |=> q.rec[fer_pkg::Q_NEUT] == $past(enc[fer_pkg::Q_NEUT]))
        else $error("operate value not captured");

    a_volt_ovf: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        s_op_capture ##0 (residual_voltage_i > 10'h019)
        |=> q.rec[fer_pkg::Q_VOLT] == fer_pkg::OVF_CODE)
        else $error("voltage overflow not coded");

    a_disp_addr: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (disp_sel_i == fer_pkg::REG_LOW_CNT)
        |=> disp_addr_o == fer_pkg::REG_LOW_CNT
            && disp_value_o == $past(q.cnt[fer_pkg::C_LOW]))
        else $error("display register mismatch");

    a_high_step: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        s_high_rise ##0 (q.cnt[fer_pkg::C_HIGH] != fer_pkg::COUNT_MAX)
        |=> q.cnt[fer_pkg::C_HIGH] == $past(q.cnt[fer_pkg::C_HIGH]) + 8'h01)
        else $error("high start count did not step");

    a_res_step: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        s_res_rise ##0 (q.cnt[fer_pkg::C_RES] != fer_pkg::COUNT_MAX)
        |=> q.cnt[fer_pkg::C_RES] == $past(q.cnt[fer_pkg::C_RES]) + 8'h01)
        else $error("residual start count did not step");

    a_fresh_record: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        s_fresh |=> q.rec == $past(enc))
        else $error("new start kept old records");

    a_track_max: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        s_track |=> q.rec[fer_pkg::Q_DIR] >= $past(enc[fer_pkg::Q_DIR]))
        else $error("record below tracked value");

    a_track_sign: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        s_track ##0 (enc[fer_pkg::Q_DIR] > q.rec[fer_pkg::Q_DIR])
        |=> q.dir_neg == $past(directional_current_i[10]))
        else $error("sign not following new maximum");

    a_dir_ovf: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        s_track ##0 (dir_mag > fer_pkg::DIR_LIMIT)
        |=> q.rec[fer_pkg::Q_DIR] == fer_pkg::OVF_CODE)
        else $error("current overflow not coded");

    a_neut_ovf: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        s_track ##0 ({1'b0, neutral_current_i} > fer_pkg::NEUT_LIMIT)
        |=> q.rec[fer_pkg::Q_NEUT] == fer_pkg::OVF_CODE)
        else $error("neutral overflow not coded");

    a_readout_map: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        s_unmapped |=> rd_data_o == 8'h00 && !rd_minus_o)
        else $error("unmapped readout not zero");

    a_disp_blank: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        !is_mapped(disp_sel_i) |=> disp_addr_o == fer_pkg::DISP_BLANK && !disp_minus_o)
        else $error("unmapped display not blank");

    a_readout_sign: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        s_dir_sel |=> rd_minus_o == $past(q.dir_neg)
            && rd_data_o == $past(q.rec[fer_pkg::Q_DIR]))
        else $error("register 1 readout mismatch");

    a_neut_show: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (disp_sel_i == fer_pkg::REG_NEUT_CUR)
        |=> disp_value_o == $past(q.rec[fer_pkg::Q_NEUT]))
        else $error("register 8 display mismatch");

    a_low_dur_show: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (rd_addr_i == fer_pkg::REG_LOW_DUR) |=> rd_data_o == $past(dur[0]))
        else $error("low duration readout mismatch");

    a_high_dur_show: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (rd_addr_i == fer_pkg::REG_HIGH_DUR) |=> rd_data_o == $past(dur[1]))
        else $error("high duration readout mismatch");

    a_supply_clear: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (supply_lost_i && !start_any && !op_any && !residual_start_i)
        |=> q.rec == '0 && q.cnt == '0)
        else $error("supply loss did not clear");

endmodule // fer_recorder

// ---- test/fer_stage_model.sv ----
`timescale 1ns/10ps
module fer_stage_model (
    input  wire logic        ref_clk_i,
    output logic             low_start_o,
    output logic             low_operate_o,
    output logic             high_start_o,
    output logic             high_operate_o,
    output logic             residual_start_o,
    output logic      [10:0] directional_current_o,
    output logic      [9:0]  residual_voltage_o,
    output logic      [9:0]  neutral_current_o
);
    // ==========================================
    // stage levels and measured quantities
    initial begin
        {low_start_o, low_operate_o, high_start_o, high_operate_o, residual_start_o} = 5'h00;
        directional_current_o = 11'h000;
        residual_voltage_o    = 10'h000;
        neutral_current_o     = 10'h000;
    end

    // levels {ls, lo, hs, ho, rs}, changed just after a falling edge
    task automatic drive(input logic [4:0] lvl, input logic [10:0] d,
                         input logic [9:0] v, input logic [9:0] n);
        @(negedge ref_clk_i);
        {low_start_o, low_operate_o, high_start_o, high_operate_o, residual_start_o} = lvl;
        directional_current_o = d;
        residual_voltage_o    = v;
        neutral_current_o     = n;
    endtask
endmodule // fer_stage_model

// ---- test/fault_event_recorder_test.sv ----
`timescale 1ns/10ps
module fault_event_recorder_test;
    localparam logic [4:0] LS = 5'h10;
    localparam logic [4:0] LO = 5'h08;
    localparam logic [4:0] HS = 5'h04;
    localparam logic [4:0] HO = 5'h02;
    localparam logic [4:0] RS = 5'h01;

    logic        ref_clk_i = 1'b0;
    logic        srst_i    = 1'b1;
    logic        ls, lo, hs, ho, rs;
    logic [10:0] dir_cur;
    logic [9:0]  res_volt, neut_cur;
    logic [15:0] low_time  = 16'hffff;
    logic [15:0] high_time = 16'hffff;
    logic        step_key  = 1'b0;
    logic        reset_key = 1'b0;
    logic        clr_cmd   = 1'b0;
    logic        supply_lost = 1'b0;
    logic [3:0]  disp_sel  = 4'h0;
    logic [3:0]  rd_addr   = 4'h0;
    logic [3:0]  disp_addr;
    logic        disp_minus, rd_minus;
    logic [7:0]  disp_value, rd_data;
    int          failures = 0;
    int          checked  = 0;

    always #50 ref_clk_i = ~ref_clk_i;

    fer_stage_model i_stage (
        .ref_clk_i(ref_clk_i), .low_start_o(ls), .low_operate_o(lo), .high_start_o(hs),
        .high_operate_o(ho), .residual_start_o(rs), .directional_current_o(dir_cur),
        .residual_voltage_o(res_volt), .neutral_current_o(neut_cur));

    fer_recorder #(.TICK_CYCLES(4)) i_dut (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .low_start_i(ls), .low_operate_i(lo),
        .high_start_i(hs), .high_operate_i(ho), .residual_start_i(rs),
        .directional_current_i(dir_cur), .residual_voltage_i(res_volt),
        .neutral_current_i(neut_cur), .low_operate_time_i(low_time),
        .high_operate_time_i(high_time), .step_key_i(step_key), .reset_key_i(reset_key),
        .clear_records_command_i(clr_cmd), .supply_lost_i(supply_lost),
        .disp_sel_i(disp_sel), .rd_addr_i(rd_addr), .disp_addr_o(disp_addr),
        .disp_minus_o(disp_minus), .disp_value_o(disp_value), .rd_data_o(rd_data),
        .rd_minus_o(rd_minus));

    // ==========================================
    // compare and access tasks
    task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    // display and readout together, one edge later
    task automatic read_reg(input logic [3:0] a, input logic [7:0] v, input logic m);
        logic [3:0] shown;
        shown = (a >= 4'h1 && a <= 4'h8) ? a : 4'h0;
        @(negedge ref_clk_i);
        rd_addr  = a;
        disp_sel = a;
        @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        check_val(rd_data, v, "readout value");
        check_val(disp_value, v, "display value");
        check_bit(rd_minus, m, "readout sign");
        check_bit(disp_minus, m, "display sign");
        check_val({4'h0, disp_addr}, {4'h0, shown}, "display number");
    endtask

    task automatic end_of_test;
        $display("checks made %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ==========================================
    // watchdog
    initial begin
        repeat (5000) @(posedge ref_clk_i);
        failures++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        end_of_test;
    end

    // ==========================================
    // tests
    initial begin
        repeat (5) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        srst_i = 1'b0;
        for (int a = 0; a < 10; a++) read_reg(4'(a), 8'h00, 1'b0);
        $display("test reset values done");

        i_stage.drive(LS, 11'h014, 10'h00a, 10'h032);
        read_reg(4'h6, 8'h00, 1'b0);
        read_reg(4'h2, 8'h0a, 1'b0);
        read_reg(4'h1, 8'h14, 1'b0);
        read_reg(4'h8, 8'h32, 1'b0);
        read_reg(4'h4, 8'h01, 1'b0);
        i_stage.drive(LS, 11'h7e2, 10'h019, 10'h032);
        i_stage.drive(LS, 11'h7e2, 10'h00f, 10'h032);
        read_reg(4'h2, 8'h19, 1'b0);
        i_stage.drive(LS, 11'h76a, 10'h01a, 10'h065);
        read_reg(4'h2, 8'hff, 1'b0);
        read_reg(4'h1, 8'hff, 1'b1);
        read_reg(4'h8, 8'hff, 1'b0);
        $display("test low-set peak tracking done");

        i_stage.drive(LS | LO, 11'h028, 10'h005, 10'h007);
        i_stage.drive(LS | LO, 11'h050, 10'h014, 10'h030);
        read_reg(4'h1, 8'h28, 1'b0);
        read_reg(4'h2, 8'h05, 1'b0);
        read_reg(4'h8, 8'h07, 1'b0);
        read_reg(4'h6, 8'h64, 1'b0);
        i_stage.drive(5'h00, 11'h050, 10'h016, 10'h030);
        read_reg(4'h2, 8'h05, 1'b0);
        $display("test low-set operate done");

        i_stage.drive(HS, 11'h000, 10'h003, 10'h002);
        read_reg(4'h7, 8'h00, 1'b0);
        read_reg(4'h2, 8'h03, 1'b0);
        read_reg(4'h5, 8'h01, 1'b0);
        i_stage.drive(HS | HO, 11'h000, 10'h01a, 10'h002);
        read_reg(4'h7, 8'h64, 1'b0);
        i_stage.drive(5'h00, 11'h000, 10'h004, 10'h002);
        $display("test high-set start and operate done");

        @(negedge ref_clk_i);
        low_time = 16'h0000;
        i_stage.drive(LS, 11'h000, 10'h001, 10'h001);
        repeat (400) @(posedge ref_clk_i);
        read_reg(4'h6, 8'h63, 1'b0);
        i_stage.drive(5'h00, 11'h000, 10'h001, 10'h001);
        $display("test start duration done");

        for (int i = 0; i < 3; i++) begin
            i_stage.drive(RS, 11'h000, 10'h001, 10'h001);
            i_stage.drive(RS, 11'h000, 10'h001, 10'h001);
            i_stage.drive(5'h00, 11'h000, 10'h001, 10'h001);
        end
        read_reg(4'h3, 8'h03, 1'b0);
        for (int i = 0; i < 260; i++) begin
            i_stage.drive(LS, 11'h000, 10'h001, 10'h001);
            i_stage.drive(5'h00, 11'h000, 10'h001, 10'h001);
        end
        read_reg(4'h4, 8'hff, 1'b0);
        $display("test start counters done");

        @(negedge ref_clk_i);
        step_key = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        step_key = 1'b0;
        read_reg(4'h4, 8'hff, 1'b0);
        for (int k = 0; k < 3; k++) begin
            i_stage.drive(LS, 11'h7f0, 10'h009, 10'h009);
            i_stage.drive(5'h00, 11'h7f0, 10'h009, 10'h009);
            @(negedge ref_clk_i);
            step_key    = (k == 0);
            reset_key   = (k == 0);
            clr_cmd     = (k == 1);
            supply_lost = (k == 2);
            @(negedge ref_clk_i);
            {step_key, reset_key, clr_cmd, supply_lost} = 4'h0;
            for (int a = 1; a < 9; a++) read_reg(4'(a), 8'h00, 1'b0);
        end
        $display("test clearing done");
        end_of_test;
    end
endmodule // fault_event_recorder_test
